// ### verilog/uartsf_core.sv
// Status, control and buffering of an asynchronous serial port
//
// Operation
// (R1) Selector 11: interrupt when buffer reaches four
// (R2) Selector 10: interrupt when buffer reaches three
// (R3) Selector 0x: interrupt on every received character
// (R4) Address detect keeps ninth-bit-set characters only; the code filters only in nine-bit mode
// (R5) Idle flag reads one while receiver idle
// (R6) Parity flag reflects head receive entry
// (R7) Framing flag reflects head receive entry
// (R8) Overrun flag set by overflow, software clears
// (R9) Clearing overrun empties buffer and shift register
// (R10) Data available while receive buffer nonempty
// (R11) Transmitter empty only when shifter and buffer empty
// (R12) Disabling transmitter aborts and flushes buffer
// (R13) Error flags stored with each receive entry
//
// Local design decisions: the register offsets and strobed register access.
`include "uartsf_map.svh"
`default_nettype none

module uartsf_core (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire uartsf_pkg::uartsf_addr_t i_addr,
  input wire uartsf_pkg::uartsf_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output var uartsf_pkg::uartsf_word_t o_rdata,
  output logic o_irq,
  input wire logic i_rx_busy,
  input wire logic i_rx_valid,
  input wire uartsf_pkg::uartsf_char_t i_rx_char,
  input wire logic i_rx_parity_err_flag,
  input wire logic i_rx_framing_err_flag,
  output logic o_tx_valid,
  output var uartsf_pkg::uartsf_char_t o_tx_char,
  input wire logic i_tx_ready,
  input wire logic i_tx_busy,
  output logic o_tx_abort,
  output logic o_tx_en,
  output logic o_nine_bit
);
  import uartsf_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Threshold test on the fill level reached by a transfer
  function automatic logic uartsf_thr_hit(input logic [1:0] sel, input logic [2:0] level);
    logic hit;
    hit = 1'b1;
    if (sel == `UARTSF_SEL_FULL) begin
      hit = (level == `UARTSF_THR_FULL); // R1
    end else if (sel == `UARTSF_SEL_3Q) begin
      hit = (level == `UARTSF_THR_3Q); // R2
    end
    return hit; // R3
  endfunction : uartsf_thr_hit

  function automatic logic [2:0] uartsf_level(input logic [2:0] cnt, input logic inc,
                                              input logic dec);
    logic [2:0] lvl;
    lvl = cnt;
    if (inc && !dec) begin
      lvl = cnt + 3'h1;
    end else if (dec && !inc) begin
      lvl = cnt - 3'h1;
    end
    return lvl;
  endfunction : uartsf_level

  // One-hot register select, shared by the strobe decode and the read data mux
  function automatic logic [5:0] uartsf_decode(input logic [`UARTSF_ADDR_W-1:0] addr);
    logic [5:0] hit;
    hit = 6'h00;
    if (addr == `UARTSF_OFS_STATUS) begin
      hit[0] = 1'b1;
    end else if (addr == `UARTSF_OFS_RXDATA) begin
      hit[1] = 1'b1;
    end else if (addr == `UARTSF_OFS_TXDATA) begin
      hit[2] = 1'b1;
    end else if (addr == `UARTSF_OFS_MODE) begin
      hit[3] = 1'b1;
    end else if (addr == `UARTSF_OFS_IRQ_STAT) begin
      hit[4] = 1'b1;
    end else if (addr == `UARTSF_OFS_IRQ_MASK) begin
      hit[5] = 1'b1;
    end
    return hit;
  endfunction : uartsf_decode

  uartsf_state_t s;
  uartsf_state_t next_s;

  // ---------------------------------------------------------------
  // Derived status
  // ---------------------------------------------------------------
  logic rx_avail;
  logic head_parity_err_flag;
  logic head_framing_err_flag;
  logic tx_full;
  logic tx_empty;
  logic rx_idle;
  uartsf_rx_entry_t head;
  uartsf_word_t status_word;

  always_comb begin
    head = s.rx_mem[s.rx_rd];
    rx_avail = (s.rx_cnt != 3'h0); // R10
    head_parity_err_flag = rx_avail && head[10]; // R6 R13
    head_framing_err_flag = rx_avail && head[9]; // R7 R13
    rx_idle = !i_rx_busy; // R5
    tx_full = (s.tx_cnt == `UARTSF_DEPTH);
    // The shifter alone is not enough: a queued or offered character also counts
    tx_empty = (s.tx_cnt == 3'h0) && !i_tx_busy; // R11
    status_word = '0;
    status_word[`UARTSF_ST_TXEN] = s.txen;
    status_word[`UARTSF_ST_TXFULL] = tx_full;
    status_word[`UARTSF_ST_TX_SHIFT_EMPTY] = tx_empty;
    status_word[`UARTSF_ST_SEL_HI:`UARTSF_ST_SEL_LO] = s.rx_sel;
    status_word[`UARTSF_ST_ADDR_DETECT_EN] = s.addr_detect_en;
    status_word[`UARTSF_ST_RX_IDLE_FLAG] = rx_idle;
    status_word[`UARTSF_ST_PARITY_ERR_FLAG] = head_parity_err_flag;
    status_word[`UARTSF_ST_FRAMING_ERR_FLAG] = head_framing_err_flag;
    status_word[`UARTSF_ST_OVERRUN_ERR_FLAG] = s.overrun_err_flag;
    status_word[`UARTSF_ST_RXDA] = rx_avail;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic wr_status;
  logic wr_tx;
  logic wr_mode;
  logic wr_mask;
  logic rd_rx;
  logic rd_irq;
  logic rx_pop;
  logic rx_push;
  logic rx_keep;
  logic rx_load;
  logic ovr_evt;
  logic ovr_clr;
  logic [2:0] rx_level;
  logic tx_push;
  logic tx_pop;
  logic tx_off;
  logic [`UARTSF_IRQ_W-1:0] irq_set;
  logic [5:0] reg_sel;

  always_comb begin
    next_s = s;
    next_s.tx_abort = 1'b0;
    wr_status = 1'b0;
    wr_tx = 1'b0;
    wr_mode = 1'b0;
    wr_mask = 1'b0;
    rd_rx = 1'b0;
    rd_irq = 1'b0;
    irq_set = '0;

    // ---------------------------------------------------------------
    // Register decode and read data
    // ---------------------------------------------------------------
    // One decode serves strobes and read mux, so they never disagree on the target
    reg_sel = uartsf_decode(i_addr);
    wr_status = i_wr && reg_sel[0];
    rd_rx = i_rd && reg_sel[1];
    wr_tx = i_wr && reg_sel[2];
    wr_mode = i_wr && reg_sel[3];
    rd_irq = i_rd && reg_sel[4];
    wr_mask = i_wr && reg_sel[5];

    // Read data, one cycle after the strobe; unmapped offsets read zero
    // The word is held between reads; only the cycle after the strobe carries meaning
    if (i_rd) begin
      next_s.rdata = '0;
      if (reg_sel[0]) begin
        next_s.rdata = status_word;
      end else if (reg_sel[1]) begin
        // An empty buffer reads zero and pops nothing
        next_s.rdata[8:0] = rx_avail ? head[8:0] : 9'h000;
      end else if (reg_sel[3]) begin
        next_s.rdata[`UARTSF_MODE_NINE] = s.nine_bit;
      end else if (reg_sel[4]) begin
        next_s.rdata[`UARTSF_IRQ_W-1:0] = s.irq_stat;
      end else if (reg_sel[5]) begin
        next_s.rdata[`UARTSF_IRQ_W-1:0] = s.irq_mask;
      end
    end

    // ---------------------------------------------------------------
    // Control writes
    // ---------------------------------------------------------------
    // Overrun can only be cleared, never set, by software
    ovr_clr = wr_status && s.overrun_err_flag && !i_wdata[`UARTSF_ST_OVERRUN_ERR_FLAG]; // R8
    tx_off = wr_status && s.txen && !i_wdata[`UARTSF_ST_TXEN];
    if (wr_status) begin
      next_s.txen = i_wdata[`UARTSF_ST_TXEN];
      next_s.rx_sel = i_wdata[`UARTSF_ST_SEL_HI:`UARTSF_ST_SEL_LO];
      next_s.addr_detect_en = i_wdata[`UARTSF_ST_ADDR_DETECT_EN];
    end
    if (wr_mode) begin
      next_s.nine_bit = i_wdata[`UARTSF_MODE_NINE];
    end
    if (wr_mask) begin
      next_s.irq_mask = i_wdata[`UARTSF_IRQ_W-1:0];
    end

    // ---------------------------------------------------------------
    // Receive path: shift register stage, then four-entry buffer
    // ---------------------------------------------------------------
    rx_pop = rd_rx && rx_avail;
    // Transfers halt while overrun is flagged, as the buffer contents are stale
    rx_push = s.sh_full && !s.overrun_err_flag && ((s.rx_cnt != `UARTSF_DEPTH) || rx_pop);
    // Filtering applies only in nine-bit mode, so eight-bit traffic passes untouched
    rx_keep = !(s.nine_bit && s.addr_detect_en && !i_rx_char[8]); // R4
    rx_load = i_rx_valid && rx_keep && !s.overrun_err_flag;
    // A new character with the stage still held means it has nowhere to go
    ovr_evt = rx_load && s.sh_full && !rx_push; // R8
    rx_level = uartsf_level(s.rx_cnt, rx_push, rx_pop);

    if (rx_push) begin
      next_s.rx_mem[s.rx_wr] = s.sh_data; // R13
      next_s.rx_wr = s.rx_wr + 2'h1;
      next_s.sh_full = 1'b0;
      irq_set[`UARTSF_IRQ_RX] = uartsf_thr_hit(s.rx_sel, rx_level); // R1 R2 R3
      irq_set[`UARTSF_IRQ_ERR] = s.sh_data[10] || s.sh_data[9];
    end
    if (rx_pop) begin
      next_s.rx_rd = s.rx_rd + 2'h1;
    end
    next_s.rx_cnt = rx_level;
    if (rx_load && !ovr_evt) begin
      next_s.sh_data = {i_rx_parity_err_flag, i_rx_framing_err_flag, i_rx_char};
      next_s.sh_full = 1'b1;
    end
    if (ovr_evt) begin
      next_s.overrun_err_flag = 1'b1;
      irq_set[`UARTSF_IRQ_OVR] = 1'b1;
    end

    if (ovr_clr) begin
      next_s.rx_rd = 2'h0; // R9
      next_s.rx_wr = 2'h0; // R9
      next_s.rx_cnt = 3'h0; // R9
      next_s.sh_full = 1'b0; // R9
      // A new overrun in the same cycle keeps the flag up
      next_s.overrun_err_flag = ovr_evt;
    end

    // ---------------------------------------------------------------
    // Transmit path: four-entry buffer feeding the character engine
    // ---------------------------------------------------------------
    // Writes while disabled or full are dropped rather than stalling the bus
    tx_push = wr_tx && s.txen && !tx_full;
    tx_pop = s.txen && (s.tx_cnt != 3'h0) && i_tx_ready;
    if (tx_push) begin
      next_s.tx_mem[s.tx_wr] = i_wdata[8:0];
      next_s.tx_wr = s.tx_wr + 2'h1;
    end
    if (tx_pop) begin
      next_s.tx_rd = s.tx_rd + 2'h1;
    end
    next_s.tx_cnt = uartsf_level(s.tx_cnt, tx_push, tx_pop);
    if (tx_off) begin
      next_s.tx_rd = 2'h0; // R12
      next_s.tx_wr = 2'h0; // R12
      next_s.tx_cnt = 3'h0; // R12
      next_s.tx_abort = 1'b1; // R12
    end

    // ---------------------------------------------------------------
    // Interrupt status: a read clears, a set in the same cycle wins
    // ---------------------------------------------------------------
    if (rd_irq) begin
      next_s.irq_stat = '0;
    end
    next_s.irq_stat = next_s.irq_stat | irq_set;

    // ---------------------------------------------------------------
    // Registered copies of the data and interrupt outputs
    // ---------------------------------------------------------------
    // Built from the next values, so the pins change at the same edge as the state
    next_s.tx_head = next_s.tx_mem[next_s.tx_rd];
    next_s.irq = |(next_s.irq_stat & next_s.irq_mask);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= '0;
      s.rx_sel <= `UARTSF_RST_SEL;
      s.irq_mask <= `UARTSF_RST_MASK;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_rdata = s.rdata;
  assign o_irq = s.irq;
  // Offered only while enabled; the abort pulse tells the engine to drop its shifter
  assign o_tx_valid = s.txen && (s.tx_cnt != 3'h0);
  assign o_tx_char = s.tx_head;
  assign o_tx_abort = s.tx_abort;
  assign o_tx_en = s.txen;
  assign o_nine_bit = s.nine_bit;

endmodule : uartsf_core

`default_nettype wire

// ### verilog/uartsf_map.svh
// Register offsets, field positions, reset values and sizes of the serial status block
`ifndef UARTSF_MAP_SVH
`define UARTSF_MAP_SVH

// ---------------------------------------------------------------
// Bus geometry
// ---------------------------------------------------------------
`define UARTSF_ADDR_W 8
`define UARTSF_DATA_W 16

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define UARTSF_OFS_STATUS 8'h00
`define UARTSF_OFS_RXDATA 8'h04
`define UARTSF_OFS_TXDATA 8'h08
`define UARTSF_OFS_MODE 8'h0c
`define UARTSF_OFS_IRQ_STAT 8'h10
`define UARTSF_OFS_IRQ_MASK 8'h14

// ---------------------------------------------------------------
// Status and control fields
// ---------------------------------------------------------------
`define UARTSF_ST_TXEN 10
`define UARTSF_ST_TXFULL 9
`define UARTSF_ST_TX_SHIFT_EMPTY 8
`define UARTSF_ST_SEL_HI 7
`define UARTSF_ST_SEL_LO 6
`define UARTSF_ST_ADDR_DETECT_EN 5
`define UARTSF_ST_RX_IDLE_FLAG 4
`define UARTSF_ST_PARITY_ERR_FLAG 3
`define UARTSF_ST_FRAMING_ERR_FLAG 2
`define UARTSF_ST_OVERRUN_ERR_FLAG 1
`define UARTSF_ST_RXDA 0
`define UARTSF_MODE_NINE 0

// ---------------------------------------------------------------
// Interrupt status bits, buffer sizes, thresholds, resets
// ---------------------------------------------------------------
`define UARTSF_IRQ_RX 0
`define UARTSF_IRQ_OVR 1
`define UARTSF_IRQ_ERR 2
`define UARTSF_IRQ_W 3
`define UARTSF_DEPTH 3'h4
`define UARTSF_THR_FULL 3'h4
`define UARTSF_THR_3Q 3'h3
`define UARTSF_SEL_FULL 2'h3
`define UARTSF_SEL_3Q 2'h2
`define UARTSF_RST_SEL 2'h0
`define UARTSF_RST_MASK 3'h0

`endif

// ### verilog/uartsf_pkg.sv
// Types shared by the serial status block
`include "uartsf_map.svh"
`default_nettype none

package uartsf_pkg;
  typedef logic [`UARTSF_ADDR_W-1:0] uartsf_addr_t;
  typedef logic [`UARTSF_DATA_W-1:0] uartsf_word_t;
  typedef logic [8:0] uartsf_char_t;
  // Receive entry: parity error, framing error, nine data bits
  typedef logic [10:0] uartsf_rx_entry_t;

  typedef struct packed {
    logic txen;
    logic [1:0] rx_sel;
    logic addr_detect_en;
    logic nine_bit;
    logic overrun_err_flag;
    logic [3:0][10:0] rx_mem;
    logic [1:0] rx_rd;
    logic [1:0] rx_wr;
    logic [2:0] rx_cnt;
    logic sh_full;
    logic [10:0] sh_data;
    logic [3:0][8:0] tx_mem;
    logic [1:0] tx_rd;
    logic [1:0] tx_wr;
    logic [2:0] tx_cnt;
    logic tx_abort;
    logic [8:0] tx_head;
    logic irq;
    logic [`UARTSF_IRQ_W-1:0] irq_stat;
    logic [`UARTSF_IRQ_W-1:0] irq_mask;
    logic [`UARTSF_DATA_W-1:0] rdata;
  } uartsf_state_t;
endpackage : uartsf_pkg

`default_nettype wire

// ### dv/uartsf_core_chk.sv
// Port checks for the serial status block
`include "uartsf_map.svh"
`default_nettype none
module uartsf_core_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire uartsf_pkg::uartsf_addr_t i_addr,
  input wire uartsf_pkg::uartsf_word_t i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire uartsf_pkg::uartsf_word_t o_rdata,
  input wire logic i_rx_busy,
  input wire logic i_tx_busy,
  input wire logic o_tx_valid,
  input wire uartsf_pkg::uartsf_char_t o_tx_char,
  input wire logic o_tx_abort,
  input wire logic o_tx_en,
  input wire logic o_nine_bit
);
  import uartsf_pkg::*;
  wire logic rd_st = i_rd && i_addr == `UARTSF_OFS_STATUS;
  wire logic wr_st = i_wr && i_addr == `UARTSF_OFS_STATUS;
  wire logic wr_tx = i_wr && i_addr == `UARTSF_OFS_TXDATA;
  wire uartsf_char_t wch = i_wdata[8:0];
  wire logic w0 = i_wdata[0];
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  chk_idle_read: assert property (rd_st |=> o_rdata[4] == !$past(i_rx_busy))
    else $error("idle flag wrong");
  chk_empty_busy: assert property (rd_st && i_tx_busy |=> !o_rdata[8])
    else $error("tx empty while shifting");
  chk_tx_queue: assert property (wr_tx && o_tx_en && !o_tx_valid
    |=> o_tx_valid && o_tx_char == $past(wch)) else $error("tx char not queued");
  chk_tx_gate: assert property (o_tx_valid |-> o_tx_en)
    else $error("tx offered while disabled");
  chk_abort_pulse: assert property (wr_st && o_tx_en && !i_wdata[10]
    |=> o_tx_abort ##1 !o_tx_abort) else $error("abort pulse wrong");
  chk_abort_flush: assert property (o_tx_abort |-> !o_tx_valid)
    else $error("tx offered during abort");
  chk_abort_cause: assert property (o_tx_abort |-> $fell(o_tx_en))
    else $error("abort without disable");
  chk_nine_mode: assert property (i_wr && i_addr == `UARTSF_OFS_MODE
    |=> o_nine_bit == $past(w0)) else $error("nine-bit mode not taken");
endmodule : uartsf_core_chk
`default_nettype wire

// ### dv/uartsf_node.sv
// Model of the remote serial engine beside the status block
`include "uartsf_map.svh"
`default_nettype none
module uartsf_node (
  input wire logic i_clk,
  input wire logic i_stall,
  output logic o_busy,
  output logic o_valid,
  output uartsf_pkg::uartsf_char_t o_char,
  output logic o_parity_err_flag,
  output logic o_framing_err_flag,
  input wire logic i_tx_valid,
  input wire uartsf_pkg::uartsf_char_t i_tx_char,
  output wire logic o_ready,
  output wire logic o_tx_busy
);
  import uartsf_pkg::*;
  uartsf_char_t got [8];
  int cnt = 0;
  int sh = 0;
  initial {o_busy, o_valid, o_char, o_parity_err_flag, o_framing_err_flag} = 13'h0aa;
  assign o_ready = i_tx_valid && !i_stall;
  assign o_tx_busy = sh != 0;
  // Shifter stays busy a few cycles after each taken character
  always @(posedge i_clk) begin
    if (o_ready) begin
      got[cnt] <= i_tx_char;
      cnt <= cnt + 1;
      sh <= 3;
    end else if (sh != 0) begin
      sh <= sh - 1;
    end
  end
  // Lines show inverted data once released, so stale values never pass
  task automatic send(input uartsf_char_t c, input logic p, input logic f);
    o_busy <= 1'b1;
    repeat (3) @(posedge i_clk);
    {o_valid, o_char, o_parity_err_flag, o_framing_err_flag} <= {1'b1, c, p, f};
    @(posedge i_clk);
    {o_busy, o_valid, o_char, o_parity_err_flag, o_framing_err_flag} <= {2'b00, ~c, ~p, ~f};
    repeat (2) @(posedge i_clk);
  endtask : send
endmodule : uartsf_node
`default_nettype wire

// ### dv/uartsf_tb_top.sv
// Self-checking bench for the serial status block
`include "uartsf_map.svh"
`default_nettype none
module uartsf_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import uartsf_pkg::*;
  localparam uartsf_addr_t a_st = `UARTSF_OFS_STATUS;
  localparam uartsf_addr_t a_rx = `UARTSF_OFS_RXDATA;
  localparam uartsf_addr_t a_tx = `UARTSF_OFS_TXDATA;
  localparam uartsf_addr_t a_is = `UARTSF_OFS_IRQ_STAT;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic stall = 1'b1;
  uartsf_addr_t i_addr = '0;
  uartsf_word_t i_wdata = '0;
  uartsf_word_t o_rdata;
  uartsf_char_t i_rx_char, o_tx_char;
  logic o_irq, i_rx_busy, i_rx_valid, i_rx_parity_err_flag, i_rx_framing_err_flag, o_tx_valid, i_tx_ready;
  logic i_tx_busy, o_tx_abort, o_tx_en, o_nine_bit;
  int n_mismatch = 0;
  int tests_run = 0;
  always #5 i_clk = ~i_clk;
  uartsf_core dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_irq, .i_rx_busy,
    .i_rx_valid, .i_rx_char, .i_rx_parity_err_flag, .i_rx_framing_err_flag, .o_tx_valid, .o_tx_char, .i_tx_ready,
    .i_tx_busy, .o_tx_abort, .o_tx_en, .o_nine_bit);
  uartsf_node node (.i_clk, .i_stall(stall), .o_busy(i_rx_busy), .o_valid(i_rx_valid),
    .o_char(i_rx_char), .o_parity_err_flag(i_rx_parity_err_flag), .o_framing_err_flag(i_rx_framing_err_flag), .i_tx_valid(o_tx_valid),
    .i_tx_char(o_tx_char), .o_ready(i_tx_ready), .o_tx_busy(i_tx_busy));
  task automatic chk(input string n, input uartsf_word_t s, input uartsf_word_t e);
    tests_run++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic guard(input int n);
    if (n >= 50) begin
      n_mismatch++;
      conclude();
    end
  endtask : guard
  // An idle edge closes each access so strobes never toggle twice in one step
  task automatic wr(input uartsf_addr_t a, input uartsf_word_t d);
    {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input string n, input uartsf_addr_t a, input uartsf_word_t e);
    {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
    chk(n, o_rdata, e);
  endtask : rd
  task automatic thresholds();
    logic e;
    for (int s = 0; s < 4; s++) begin
      wr(a_st, 16'(s << 6));
      for (int k = 1; k <= 4; k++) begin
        node.send(9'(k), 1'b0, 1'b0);
        e = s < 2 || s == 2 && k == 3 || s == 3 && k == 4;
        chk("irq", 16'(o_irq), 16'(e));
        rd("irqstat", a_is, 16'(e));
      end
      for (int k = 1; k <= 4; k++) rd("rxdata", a_rx, 16'(k));
      rd("status", a_st, 16'h0110 | 16'(s << 6));
    end
    $display("thresholds done");
  endtask : thresholds
  task automatic errors();
    wr(a_st, 16'h0000);
    fork
      node.send(9'h0a1, 1'b1, 1'b0);
      rd("status", a_st, 16'h0100);
    join
    node.send(9'h0a2, 1'b0, 1'b1);
    rd("status", a_st, 16'h0119);
    rd("rxdata", a_rx, 16'h00a1);
    rd("status", a_st, 16'h0115);
    rd("rxdata", a_rx, 16'h00a2);
    rd("status", a_st, 16'h0110);
    rd("irqstat", a_is, 16'h0005);
    $display("errors done");
  endtask : errors
  task automatic overrun();
    for (int k = 0; k < 6; k++) node.send(9'(k), 1'b0, 1'b0);
    rd("status", a_st, 16'h0113);
    wr(a_st, 16'h0002);
    rd("status", a_st, 16'h0113);
    wr(a_st, 16'h0000);
    rd("status", a_st, 16'h0110);
    wr(a_st, 16'h0002);
    rd("status", a_st, 16'h0110);
    rd("rxdata", a_rx, 16'h0000);
    rd("irqstat", a_is, 16'h0003);
    $display("overrun done");
  endtask : overrun
  task automatic addr_det();
    wr(a_st, 16'h0020);
    node.send(9'h055, 1'b0, 1'b0);
    rd("rxdata", a_rx, 16'h0055);
    wr(`UARTSF_OFS_MODE, 16'h0001);
    rd("mode", `UARTSF_OFS_MODE, 16'h0001);
    node.send(9'h056, 1'b0, 1'b0);
    node.send(9'h157, 1'b0, 1'b0);
    rd("rxdata", a_rx, 16'h0157);
    rd("status", a_st, 16'h0130);
    $display("address detect done");
  endtask : addr_det
  task automatic tx();
    int n;
    wr(a_st, 16'h0400);
    for (int k = 0; k < 3; k++) wr(a_tx, 16'h0100 + 16'(k));
    rd("status", a_st, 16'h0410);
    stall <= 1'b0;
    for (n = 0; node.cnt < 3 && n < 50; n++) @(posedge i_clk);
    guard(n);
    rd("status", a_st, 16'h0410);
    for (int k = 0; k < 3; k++) chk("txchar", 16'(node.got[k]), 16'h0100 + 16'(k));
    for (n = 0; i_tx_busy && n < 50; n++) @(posedge i_clk);
    guard(n);
    rd("status", a_st, 16'h0510);
    stall <= 1'b1;
    for (int k = 0; k < 4; k++) wr(a_tx, 16'h0011 + 16'(k));
    rd("status", a_st, 16'h0610);
    wr(a_st, 16'h0000);
    wr(a_st, 16'h0400);
    chk("txvalid", 16'(o_tx_valid), 16'h0000);
    rd("status", a_st, 16'h0510);
    chk("txcount", 16'(node.cnt), 16'h0003);
    $display("transmit done");
  endtask : tx
  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd("status", a_st, 16'h0110);
    wr(`UARTSF_OFS_IRQ_MASK, 16'h0001);
    rd("mask", `UARTSF_OFS_IRQ_MASK, 16'h0001);
    thresholds();
    errors();
    overrun();
    addr_det();
    tx();
    conclude();
  end
endmodule : uartsf_tb_top
bind uartsf_core uartsf_core_chk chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
  .i_rx_busy, .i_tx_busy, .o_tx_valid, .o_tx_char, .o_tx_abort, .o_tx_en, .o_nine_bit);
`default_nettype wire
